// File: hw/mfv_ctrl.sv
// Pause flow control, backpressure, VLAN tag detection and remote wake-up
//
// Summary of operation
// - Full duplex with enable: valid received pause holds transmitter quanta times slot time.
// - Enable clear: no pause decoding, no hold-off from received frames.
// - Half duplex: enable bit gates backpressure toward the link.
// - Busy reads high while pause frame or backpressure is sent; clears after.
// - Tagged frames may be 1522 bytes long instead of 1518.
// - First tag identifier compared with bytes 13 and 14 of each frame.
// - Second tag identifier compared with bytes 13 and 14 of each frame.
// - Wake frame filter is a write-only 32-bit configuration word.
// - Unicast wake enable: global unicast frame ends power saving.
// - Valid wake-up frame sets wake frame received flag.
// - Valid wake pattern packet sets wake pattern received flag.
// - Wake frame enable turns on filter-based wake-up frame detection.
// - Wake pattern enable turns on wake pattern packet detection.
// - No pause frames or backpressure while transmitter disabled.
// - Pause time field supplies the time sent in each pause frame.
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
module mfv_ctrl
	import mfv_pkg::*;
#(
	parameter int SLOT_CYC_SLOW_P = SLOT_CYC_SLOW
)(
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         reset,
	// Register port
	input  wire mfv_reg_req_s reg_req,
	output logic [31:0]       reg_rdata,
	// Receive byte stream
	input  wire mfv_rx_s      rx,
	// Line and MAC state
	input  wire logic         full_duplex,
	input  wire logic         speed_fast,
	input  wire logic         tx_enable,
	input  wire logic         power_save,
	input  wire logic [47:0]  station_addr,
	// Transmit flow control
	input  wire logic         pause_send_req,
	input  wire logic         pause_tx_done,
	input  wire logic         bp_request,
	output logic              pause_tx_start,
	output logic [15:0]       pause_tx_time,
	output logic              backpressure,
	output logic              tx_pause_hold,
	// Status
	output logic              rx_tagged,
	output logic              rx_len_error,
	output logic              wake_request,
	output logic              irq
);
	// ==================================================================
	// Registers
	logic [15:0]         pause_time_value;
	logic                pause_decode_enable;
	logic                pass_ctrl;
	logic                pause_tx_busy;
	logic [15:0]         first_tag_identifier;
	logic [15:0]         second_tag_identifier;
	logic [31:0]         wake_frame_filter;
	logic                wake_frame_enable;
	logic                wake_pattern_enable;
	logic                global_unicast_wake_enable;
	logic                wake_frame_received;
	logic                wake_pattern_received;
	logic [IRQ_BITS-1:0] irq_status;
	logic [IRQ_BITS-1:0] irq_mask;
	logic [IRQ_BITS-1:0] irq_event;
	logic                wr_flow;
	logic                wr_csr;

	assign wr_flow = reg_req.wr && (reg_req.addr == REG_FLOW);
	assign wr_csr  = reg_req.wr && (reg_req.addr == REG_WAKE_CSR);

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			pause_time_value           <= RESET_VALUE[15:0];
			pause_decode_enable        <= 1'b0;
			pass_ctrl                  <= 1'b0;
			first_tag_identifier       <= RESET_VALUE[15:0];
			second_tag_identifier      <= RESET_VALUE[15:0];
			wake_frame_filter          <= RESET_VALUE;
			wake_frame_enable          <= 1'b0;
			wake_pattern_enable        <= 1'b0;
			global_unicast_wake_enable <= 1'b0;
			irq_mask                   <= RESET_VALUE[IRQ_BITS-1:0];
		end
		else if (reg_req.wr)
		begin
			case (reg_req.addr)
				REG_FLOW:
				begin
					pause_time_value    <= reg_req.wdata[FLOW_PT_LSB +: 16];
					pause_decode_enable <= reg_req.wdata[FLOW_EN_BIT];
					pass_ctrl           <= reg_req.wdata[FLOW_PASS_BIT];
				end
				REG_VLAN_ONE:  first_tag_identifier  <= reg_req.wdata[15:0];
				REG_VLAN_TWO:  second_tag_identifier <= reg_req.wdata[15:0];
				REG_WAKE_FILT: wake_frame_filter     <= reg_req.wdata;
				REG_WAKE_CSR:
				begin
					wake_frame_enable          <= reg_req.wdata[WK_FRM_EN_BIT];
					wake_pattern_enable        <= reg_req.wdata[WK_PAT_EN_BIT];
					global_unicast_wake_enable <= reg_req.wdata[WK_UNI_EN_BIT];
				end
				REG_IRQ_MASK:  irq_mask <= reg_req.wdata[IRQ_BITS-1:0];
				default:       irq_mask <= irq_mask;
			endcase
		end
	end

	// Read data one cycle after the strobe; filter reads as zero
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			reg_rdata <= RESET_VALUE;
		else if (!reg_req.rd)
			reg_rdata <= RESET_VALUE;
		else
		begin
			reg_rdata <= RESET_VALUE;
			case (reg_req.addr)
				REG_FLOW:
				begin
					reg_rdata[FLOW_PT_LSB +: 16] <= pause_time_value;
					reg_rdata[FLOW_PASS_BIT]     <= pass_ctrl;
					reg_rdata[FLOW_EN_BIT]       <= pause_decode_enable;
					reg_rdata[FLOW_BUSY_BIT]     <= pause_tx_busy;
				end
				REG_VLAN_ONE: reg_rdata[15:0] <= first_tag_identifier;
				REG_VLAN_TWO: reg_rdata[15:0] <= second_tag_identifier;
				REG_WAKE_CSR:
				begin
					reg_rdata[WK_UNI_EN_BIT] <= global_unicast_wake_enable;
					reg_rdata[WK_FRM_RX_BIT] <= wake_frame_received;
					reg_rdata[WK_PAT_RX_BIT] <= wake_pattern_received;
					reg_rdata[WK_FRM_EN_BIT] <= wake_frame_enable;
					reg_rdata[WK_PAT_EN_BIT] <= wake_pattern_enable;
				end
				REG_IRQ_STAT: reg_rdata[IRQ_BITS-1:0] <= irq_status;
				REG_IRQ_MASK: reg_rdata[IRQ_BITS-1:0] <= irq_mask;
				default:      reg_rdata <= RESET_VALUE;
			endcase
		end
	end

	// ==================================================================
	// Receive frame parsing
	logic [10:0] byte_idx;
	logic [7:0]  da_first;
	logic        da_is_pause;
	logic [15:0] frame_type;
	logic [15:0] frame_opcode;
	logic [15:0] frame_quanta;
	logic [15:0] filt_word;
	logic [10:0] frame_len;
	logic        frame_end;
	logic        tag_hit;

	assign frame_len = (byte_idx == LEN_SAT) ? LEN_SAT : byte_idx + 11'd1;
	assign frame_end = rx.valid && rx.eof && rx.good;

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			byte_idx     <= 11'h000;
			da_first     <= 8'h00;
			da_is_pause  <= 1'b0;
			frame_type   <= 16'h0000;
			frame_opcode <= 16'h0000;
			frame_quanta <= 16'h0000;
			filt_word    <= 16'h0000;
		end
		else if (rx.valid)
		begin
			byte_idx <= rx.sof ? 11'h001 : ((byte_idx == LEN_SAT) ? LEN_SAT : byte_idx + 11'd1);
			if (rx.sof)
			begin
				da_first    <= rx.data;
				da_is_pause <= (rx.data == PAUSE_DA[47:40]);
			end
			else if (byte_idx < IDX_DA_END)
				da_is_pause <= da_is_pause && (rx.data == PAUSE_DA[8*(5-byte_idx[2:0]) +: 8]);
			if (byte_idx == IDX_TYPE_HI) frame_type[15:8]   <= rx.data;
			if (byte_idx == IDX_TYPE_LO) frame_type[7:0]    <= rx.data;
			if (byte_idx == IDX_OP_HI)   frame_opcode[15:8] <= rx.data;
			if (byte_idx == IDX_OP_LO)   frame_opcode[7:0]  <= rx.data;
			if (byte_idx == IDX_PT_HI)   frame_quanta[15:8] <= rx.data;
			if (byte_idx == IDX_PT_LO)   frame_quanta[7:0]  <= rx.data;
			if (!rx.sof && byte_idx == {3'b000, wake_frame_filter[7:0]})
				filt_word[15:8] <= rx.data;
			if (!rx.sof && byte_idx == {3'b000, wake_frame_filter[7:0]} + 11'd1)
				filt_word[7:0] <= rx.data;
		end
	end

	// Tag identifiers match the type bytes
	assign tag_hit = (frame_type == first_tag_identifier)
		|| (frame_type == second_tag_identifier);

	// ==================================================================
	// Frame length check and tag report
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			rx_tagged    <= 1'b0;
			rx_len_error <= 1'b0;
		end
		else
		begin
			rx_tagged    <= frame_end && tag_hit;
			rx_len_error <= frame_end && (frame_len > (tag_hit ? MAX_LEN_TAGGED : MAX_LEN_PLAIN));
		end
	end

	// ==================================================================
	// Received pause decode and transmit hold-off
	logic        pause_accept;
	logic [15:0] quanta_left;
	logic [12:0] slot_cnt;
	logic [12:0] slot_last;

	assign pause_accept = frame_end && pause_decode_enable && full_duplex && da_is_pause
		&& frame_type == CTRL_TYPE && frame_opcode == PAUSE_OPCODE;
	assign slot_last = speed_fast ? 13'(SLOT_CYC_FAST - 1) : 13'(SLOT_CYC_SLOW_P - 1);

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			quanta_left   <= 16'h0000;
			slot_cnt      <= 13'h0000;
			tx_pause_hold <= 1'b0;
		end
		else if (pause_accept)
		begin
			quanta_left   <= frame_quanta;
			slot_cnt      <= 13'h0000;
			tx_pause_hold <= (frame_quanta != 16'h0000);
		end
		else if (quanta_left != 16'h0000)
		begin
			if (slot_cnt == slot_last)
			begin
				slot_cnt      <= 13'h0000;
				quanta_left   <= quanta_left - 16'd1;
				tx_pause_hold <= (quanta_left != 16'd1);
			end
			else
				slot_cnt <= slot_cnt + 13'd1;
		end
		else
			tx_pause_hold <= 1'b0;
	end

	// ==================================================================
	// Pause transmission and backpressure
	logic fd_sending;

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			fd_sending     <= 1'b0;
			pause_tx_start <= 1'b0;
			pause_tx_time  <= 16'h0000;
			backpressure   <= 1'b0;
		end
		else
		begin
			pause_tx_start <= 1'b0;
			if (pause_send_req && full_duplex && tx_enable && !fd_sending)
			begin
				fd_sending     <= 1'b1;
				pause_tx_start <= 1'b1;
				pause_tx_time  <= pause_time_value;
			end
			else if (pause_tx_done)
				fd_sending <= 1'b0;
			backpressure <= pause_decode_enable && !full_duplex && tx_enable && bp_request;
		end
	end

	assign pause_tx_busy = fd_sending || backpressure;

	// ==================================================================
	// Wake pattern detection
	logic [2:0] sync_cnt;
	logic [2:0] addr_pos;
	logic [3:0] rep_cnt;
	logic       in_addr;
	logic       pat_seen;
	logic [7:0] addr_byte;

	assign addr_byte = station_addr[8*(5-addr_pos) +: 8];

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			sync_cnt <= 3'd0;
			addr_pos <= 3'd0;
			rep_cnt  <= 4'd0;
			in_addr  <= 1'b0;
			pat_seen <= 1'b0;
		end
		else if (rx.valid)
		begin
			if (rx.sof)
				pat_seen <= 1'b0;
			if (in_addr && rx.data == addr_byte && !rx.sof)
			begin
				addr_pos <= (addr_pos == PAT_ADDR_LAST) ? 3'd0 : addr_pos + 3'd1;
				if (addr_pos == PAT_ADDR_LAST)
				begin
					rep_cnt <= rep_cnt + 4'd1;
					if (rep_cnt == PAT_REP_LAST)
					begin
						pat_seen <= wake_pattern_enable;
						in_addr  <= 1'b0;
					end
				end
			end
			else if (rx.data == PAT_SYNC_BYTE)
			begin
				in_addr  <= 1'b0;
				sync_cnt <= (sync_cnt == PAT_SYNC_LEN) ? sync_cnt : sync_cnt + 3'd1;
			end
			else
			begin
				in_addr  <= (sync_cnt == PAT_SYNC_LEN) && (rx.data == station_addr[47:40]) && !rx.sof;
				addr_pos <= 3'd1;
				rep_cnt  <= 4'd0;
				sync_cnt <= 3'd0;
			end
		end
	end

	// ==================================================================
	// Wake events, flags and interrupt
	logic wake_frame_hit;
	logic wake_pattern_hit;
	logic unicast_hit;

	assign wake_frame_hit   = frame_end && wake_frame_enable && filt_word == wake_frame_filter[31:16];
	assign wake_pattern_hit = frame_end && pat_seen;
	assign unicast_hit      = frame_end && global_unicast_wake_enable && power_save
		&& da_first[1:0] == 2'b00;
	assign irq_event[IRQ_PAUSE_RX] = pause_accept;
	assign irq_event[IRQ_WAKE_FRM] = wake_frame_hit;
	assign irq_event[IRQ_WAKE_PAT] = wake_pattern_hit;
	assign irq_event[IRQ_UNI_WAKE] = unicast_hit;
	assign irq_event[IRQ_LEN_ERR]  = frame_end && (frame_len > (tag_hit ? MAX_LEN_TAGGED : MAX_LEN_PLAIN));

	// Set wins over write-one-to-clear
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			wake_frame_received   <= 1'b0;
			wake_pattern_received <= 1'b0;
			wake_request          <= 1'b0;
		end
		else
		begin
			wake_frame_received   <= wake_frame_hit
				|| (wake_frame_received && !(wr_csr && reg_req.wdata[WK_FRM_RX_BIT]));
			wake_pattern_received <= wake_pattern_hit
				|| (wake_pattern_received && !(wr_csr && reg_req.wdata[WK_PAT_RX_BIT]));
			wake_request          <= unicast_hit || wake_frame_hit || wake_pattern_hit;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < IRQ_BITS; gi++)
		begin : g_irq
			always_ff @(posedge clock or posedge reset)
			begin
				if (reset)
					irq_status[gi] <= 1'b0;
				else
					irq_status[gi] <= irq_event[gi] || (irq_status[gi]
						&& !(reg_req.wr && reg_req.addr == REG_IRQ_STAT && reg_req.wdata[gi]));
			end
		end
	endgenerate

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			irq <= 1'b0;
		else
			irq <= |(irq_status & irq_mask);
	end

	// ==================================================================
	// Assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	sequence s_pause_start;
		pause_send_req && full_duplex && tx_enable && !fd_sending;
	endsequence

	sequence s_pause_done;
		pause_tx_done && !pause_send_req;
	endsequence

	a_hold_after_pause: assert property (pause_accept && frame_quanta != 16'h0000 |=> tx_pause_hold)
		else $error("hold-off did not follow accepted pause");
	a_no_decode_off: assert property (!pause_decode_enable |-> !pause_accept)
		else $error("pause decoded while flow control disabled");
	a_bp_half_only: assert property ($rose(backpressure) |-> !$past(full_duplex) && $past(pause_decode_enable))
		else $error("backpressure outside half duplex or when disabled");
	a_busy_start: assert property (s_pause_start |=> pause_tx_busy [*1] ##0 pause_tx_start)
		else $error("busy not set when pause frame started");
	a_busy_clear: assert property (fd_sending && !backpressure ##0 s_pause_done ##1 !bp_request && !pause_send_req
		|=> !pause_tx_busy)
		else $error("busy not cleared after pause frame sent");
	a_tx_off_quiet: assert property (pause_tx_start || $rose(backpressure) |-> $past(tx_enable))
		else $error("flow control activity with transmitter disabled");
	a_time_sent: assert property (pause_tx_start |-> pause_tx_time == $past(pause_time_value))
		else $error("pause time mismatch");
	a_tagged_len: assert property (frame_end && tag_hit && frame_len == MAX_LEN_TAGGED |=> !rx_len_error)
		else $error("tagged frame of legal length flagged");
	a_plain_len: assert property (frame_end && !tag_hit && frame_len > MAX_LEN_PLAIN |=> rx_len_error)
		else $error("overlong untagged frame not flagged");
	a_wake_frame_flag: assert property (wake_frame_hit |=> wake_frame_received && wake_request)
		else $error("wake frame flag not set");
	a_wake_pat_flag: assert property (wake_pattern_hit |=> wake_pattern_received
		##1 (wake_pattern_received || $past(wr_csr)))
		else $error("wake pattern flag not set");
	a_unicast_wake: assert property (unicast_hit |=> wake_request)
		else $error("unicast wake missed");
	a_irq_level: assert property (|(irq_status & irq_mask) |=> irq)
		else $error("interrupt not raised");
endmodule : mfv_ctrl

// File: include/mfv_pkg.sv
// Constants and carrier types for the flow control, VLAN and wake-up block
package mfv_pkg;
	// Register indices
	localparam logic [3:0]  REG_FLOW       = 4'h8;
	localparam logic [3:0]  REG_VLAN_ONE   = 4'h9;
	localparam logic [3:0]  REG_VLAN_TWO   = 4'hA;
	localparam logic [3:0]  REG_WAKE_FILT  = 4'hB;
	localparam logic [3:0]  REG_WAKE_CSR   = 4'hC;
	localparam logic [3:0]  REG_IRQ_STAT   = 4'hD;
	localparam logic [3:0]  REG_IRQ_MASK   = 4'hE;
	localparam logic [31:0] RESET_VALUE    = 32'h0000_0000;
	// Flow register fields
	localparam int          FLOW_BUSY_BIT  = 0;
	localparam int          FLOW_EN_BIT    = 1;
	localparam int          FLOW_PASS_BIT  = 2;
	localparam int          FLOW_PT_LSB    = 16;
	// Wake control and status fields
	localparam int          WK_PAT_EN_BIT  = 1;
	localparam int          WK_FRM_EN_BIT  = 2;
	localparam int          WK_PAT_RX_BIT  = 5;
	localparam int          WK_FRM_RX_BIT  = 6;
	localparam int          WK_UNI_EN_BIT  = 9;
	// Interrupt status bits
	localparam int          IRQ_PAUSE_RX   = 0;
	localparam int          IRQ_WAKE_FRM   = 1;
	localparam int          IRQ_WAKE_PAT   = 2;
	localparam int          IRQ_UNI_WAKE   = 3;
	localparam int          IRQ_LEN_ERR    = 4;
	localparam int          IRQ_BITS       = 5;
	// Frame layout
	localparam logic [47:0] PAUSE_DA       = 48'h0180_C200_0001;
	localparam logic [15:0] CTRL_TYPE      = 16'h8808;
	localparam logic [15:0] PAUSE_OPCODE   = 16'h0001;
	localparam logic [10:0] IDX_TYPE_HI    = 11'h00C;
	localparam logic [10:0] IDX_TYPE_LO    = 11'h00D;
	localparam logic [10:0] IDX_OP_HI      = 11'h00E;
	localparam logic [10:0] IDX_OP_LO      = 11'h00F;
	localparam logic [10:0] IDX_PT_HI      = 11'h010;
	localparam logic [10:0] IDX_PT_LO      = 11'h011;
	localparam logic [10:0] IDX_DA_END     = 11'h006;
	localparam logic [10:0] MAX_LEN_PLAIN  = 11'd1518;
	localparam logic [10:0] MAX_LEN_TAGGED = 11'd1522;
	localparam logic [10:0] LEN_SAT        = 11'h7FF;
	// Wake pattern: sync run then repeated station address
	localparam logic [2:0]  PAT_SYNC_LEN   = 3'd6;
	localparam logic [2:0]  PAT_ADDR_LAST  = 3'd5;
	localparam logic [3:0]  PAT_REP_LAST   = 4'd15;
	localparam logic [7:0]  PAT_SYNC_BYTE  = 8'hFF;
	// Slot time timing: 512 bit times at line rate
	localparam int          CLK_MHZ        = 100;
	localparam int          SLOT_BITS      = 512;
	localparam int          RATE_FAST_MBPS = 100;
	localparam int          RATE_SLOW_MBPS = 10;
	localparam int          SLOT_CYC_FAST  = SLOT_BITS * CLK_MHZ / RATE_FAST_MBPS;
	localparam int          SLOT_CYC_SLOW  = SLOT_BITS * CLK_MHZ / RATE_SLOW_MBPS;

	typedef struct packed {
		logic       valid;
		logic       sof;
		logic       eof;
		logic       good;
		logic [7:0] data;
	} mfv_rx_s;

	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} mfv_reg_req_s;
endpackage : mfv_pkg

// File: test/mfv_link_model.sv
// Link partner model: receive frame source and pause transmit completion
`timescale 1ns/100ps
module mfv_link_model
	import mfv_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// Pause transmit handshake
	input  wire logic       pause_tx_start,
	input  wire logic [7:0] done_delay,
	output logic            pause_tx_done,
	// Receive stream toward the block
	output mfv_rx_s         rx
);
	logic [7:0] dcnt;

	initial rx = '0;

	// ==========================================
	// Pause frame ends done_delay + 1 cycles after start rises
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			dcnt          <= 8'h00;
			pause_tx_done <= 1'b0;
		end
		else
		begin
			pause_tx_done <= (dcnt == 8'h01);
			if (pause_tx_start)
				dcnt <= done_delay;
			else if (dcnt != 8'h00)
				dcnt <= dcnt - 8'h01;
		end
	end

	// ==========================================
	// One byte a cycle; idle data inverted so it never looks held
	task send_frame(input logic [7:0] b[$], input logic good);
		for (int i = 0; i < b.size(); i++)
		begin
			@(posedge clock);
			rx <= '{valid: 1'b1, sof: (i == 0), eof: (i == b.size() - 1), good: good, data: b[i]};
		end
		@(posedge clock);
		rx <= '{valid: 1'b0, sof: 1'b0, eof: 1'b0, good: 1'b0, data: ~b[b.size() - 1]};
	endtask : send_frame
endmodule : mfv_link_model

// File: test/tb.sv
// Self-checking bench for the flow control, VLAN and wake-up block
`timescale 1ns/100ps
module tb;
	import mfv_pkg::*;
	localparam int SLOW = 8;
	logic         clock, reset, full_duplex, speed_fast, tx_enable, power_save;
	logic         pause_send_req, pause_tx_done, bp_request, pause_tx_start;
	logic         backpressure, tx_pause_hold, rx_tagged, rx_len_error, wake_request, irq;
	logic [15:0]  pause_tx_time, pt, q;
	logic [31:0]  reg_rdata, rv;
	logic [47:0]  station_addr;
	logic [7:0]   done_delay;
	logic [7:0]   fq[$];
	mfv_reg_req_s reg_req;
	mfv_rx_s      rx;
	int           seed = 49, n_fail = 0, checks = 0, b, t, l, w;
	int           n_hold = 0, n_tag = 0, n_len = 0, n_wake = 0, n_start = 0;

	mfv_ctrl #(.SLOT_CYC_SLOW_P(SLOW)) u_dut (.clock(clock), .reset(reset), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .rx(rx), .full_duplex(full_duplex), .speed_fast(speed_fast),
		.tx_enable(tx_enable), .power_save(power_save), .station_addr(station_addr),
		.pause_send_req(pause_send_req), .pause_tx_done(pause_tx_done), .bp_request(bp_request),
		.pause_tx_start(pause_tx_start), .pause_tx_time(pause_tx_time), .backpressure(backpressure),
		.tx_pause_hold(tx_pause_hold), .rx_tagged(rx_tagged), .rx_len_error(rx_len_error),
		.wake_request(wake_request), .irq(irq));
	mfv_link_model u_link (.clock(clock), .reset(reset), .pause_tx_start(pause_tx_start),
		.done_delay(done_delay), .pause_tx_done(pause_tx_done), .rx(rx));

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock)
	begin
		n_hold  += (tx_pause_hold === 1'b1);
		n_tag   += (rx_tagged === 1'b1);
		n_len   += (rx_len_error === 1'b1);
		n_wake  += (wake_request === 1'b1);
		n_start += (pause_tx_start === 1'b1);
	end

	// ==========================================
	// Checking and closing
	function int hold_cycles(input logic [15:0] quanta, input logic fast);
		return quanta * (fast ? 512 : SLOW);
	endfunction : hold_cycles

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task wrap_up;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	// ==========================================
	// Register port and stimulus helpers
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		reg_req.wr <= 1'b0;
	endtask : wr

	task rd(input logic [3:0] a);
		@(posedge clock);
		reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		reg_req.rd <= 1'b0;
		@(negedge clock);
		rv = reg_rdata;
	endtask : rd

	task frame(input logic [47:0] da, input logic [15:0] ty, input int len);
		fq.delete();
		for (int i = 0; i < len; i++)
			fq.push_back(8'($random(seed)));
		for (int i = 0; i < 6; i++)
			fq[i] = da[47 - 8 * i -: 8];
		fq[12] = ty[15:8];
		fq[13] = ty[7:0];
	endtask : frame

	task send;
		u_link.send_frame(fq, 1'b1);
		repeat (4) @(posedge clock);
	endtask : send

	task pause_req;
		@(posedge clock);
		pause_send_req <= 1'b1;
		@(posedge clock);
		pause_send_req <= 1'b0;
		@(negedge clock);
	endtask : pause_req

	initial
	begin
		repeat (40000) @(posedge clock);
		n_fail++;
		wrap_up;
	end

	// ==========================================
	// Main sequence
	initial
	begin
		reset = 1'b1;
		reg_req = '0;
		full_duplex = 1'b1;
		speed_fast = 1'b0;
		tx_enable = 1'b1;
		power_save = 1'b0;
		pause_send_req = 1'b0;
		bp_request = 1'b0;
		done_delay = 8'd20;
		// First address byte never equals the sync byte
		station_addr = {16'($random(seed)) & 16'h7FFF, 32'($random(seed))};
		pt = 16'($random(seed));
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		for (int a = 0; a < 16; a++)
		begin
			rd(4'(a));
			chk(rv, 32'h0);
		end
		wr(REG_FLOW, {pt, 16'h0002});
		rd(REG_FLOW);
		chk(rv, {pt, 16'h0002});
		t = n_start;
		pause_req;
		chk(pause_tx_start, 1'b1);
		chk(pause_tx_time, pt);
		rd(REG_FLOW);
		chk(rv[0], 1'b1);
		repeat (30) @(posedge clock);
		rd(REG_FLOW);
		chk(rv[0], 1'b0);
		tx_enable <= 1'b0;
		pause_req;
		repeat (3) @(posedge clock);
		chk(n_start - t, 1);
		tx_enable <= 1'b1;
		for (int f = 0; f < 3; f++)
		begin
			speed_fast <= f[0];
			q = f[0] ? 16'h1 : 16'h1 + 16'($random(seed) & 3);
			if (f == 2)
				wr(REG_FLOW, {pt, 16'h0000});
			frame(PAUSE_DA, CTRL_TYPE, 64);
			{fq[14], fq[15], fq[16], fq[17]} = {PAUSE_OPCODE, q};
			b = n_hold;
			send;
			repeat (hold_cycles(q, f[0]) + 8) @(posedge clock);
			chk(n_hold - b, f == 2 ? 0 : hold_cycles(q, f[0]));
			wr(REG_FLOW, {pt, 16'h0002});
		end
		full_duplex <= 1'b0;
		bp_request <= 1'b1;
		repeat (3) @(posedge clock);
		@(negedge clock);
		chk(backpressure, 1'b1);
		rd(REG_FLOW);
		chk(rv[0], 1'b1);
		tx_enable <= 1'b0;
		repeat (3) @(posedge clock);
		@(negedge clock);
		chk(backpressure, 1'b0);
		rd(REG_FLOW);
		chk(rv[0], 1'b0);
		wr(REG_FLOW, 32'h0);
		tx_enable <= 1'b1;
		repeat (3) @(posedge clock);
		@(negedge clock);
		chk(backpressure, 1'b0);
		bp_request <= 1'b0;
		full_duplex <= 1'b1;
		for (int k = 0; k < 8; k++)
		begin
			wr(REG_VLAN_ONE, k[2] ? 32'h0 : 32'h8100);
			wr(REG_VLAN_TWO, k[2] ? 32'h8100 : 32'h0);
			rd(k[2] ? REG_VLAN_TWO : REG_VLAN_ONE);
			chk(rv[15:0], 16'h8100);
			frame(48'h0200_0000_0001, k[1] ? 16'h0800 : 16'h8100, (k[1] ? 1518 : 1522) + k[0]);
			t = n_tag;
			l = n_len;
			send;
			chk(n_tag - t, !k[1]);
			chk(n_len - l, k[0]);
		end
		wr(REG_IRQ_MASK, 32'h2);
		wr(REG_WAKE_FILT, {16'hA5C3, 8'h00, 8'd20});
		for (int e = 0; e < 2; e++)
		begin
			wr(REG_WAKE_CSR, e ? 32'h0 : 32'h4);
			frame(48'h0200_0000_0001, 16'h0800, 64);
			{fq[20], fq[21]} = 16'hA5C3;
			w = n_wake;
			send;
			chk(n_wake - w, !e);
			rd(REG_WAKE_CSR);
			chk(rv, e ? 32'h0 : 32'h44);
			chk(irq, !e);
			wr(REG_IRQ_STAT, 32'h2);
			wr(REG_WAKE_CSR, 32'h40);
		end
		rd(REG_WAKE_FILT);
		chk(rv, 32'h0);
		wr(REG_WAKE_CSR, 32'h2);
		frame(48'h0200_0000_0001, 16'h0800, 130);
		for (int i = 0; i < 102; i++)
			fq[20 + i] = i < 6 ? 8'hFF : station_addr[47 - 8 * ((i - 6) % 6) -: 8];
		send;
		rd(REG_WAKE_CSR);
		chk(rv, 32'h22);
		chk(irq, 1'b0);
		wr(REG_WAKE_CSR, 32'h220);
		power_save <= 1'b1;
		for (int u = 0; u < 2; u++)
		begin
			frame({7'h0, u[0], 40'h0}, 16'h0800, 64);
			w = n_wake;
			send;
			chk(n_wake - w, !u);
		end
		rd(REG_IRQ_STAT);
		chk(rv[3], 1'b1);
		wrap_up;
	end
endmodule : tb
